// >>> shared/mix_router_pkg.sv
// Package with constants, field layout and carriers of the mixing router.
package mix_router_pkg;

  // ==========================================================================
  // Sample carriers.
  localparam int SAMPLE_W = 24;
  typedef logic signed [SAMPLE_W-1:0] sample_t;
  typedef struct packed {
    sample_t left;
    sample_t right;
  } stereo_t;
  localparam sample_t SAMPLE_MAX  = 24'sh7FFFFF;
  localparam sample_t SAMPLE_MIN  = 24'sh800000;
  localparam sample_t SAMPLE_ZERO = 24'sh000000;

  // ==========================================================================
  // APB carriers.
  localparam int ADDR_W = 12;
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } apb_req_t;
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

  // ==========================================================================
  // Register indices; the byte address is the index shifted by BYTE_SHIFT.
  localparam int BYTE_SHIFT = 2;
  localparam logic [9:0] IDX_CTRL_ONE  = 10'h005;
  localparam logic [9:0] IDX_CTRL_TWO  = 10'h006;
  localparam logic [9:0] IDX_PORT_ZERO = 10'h007;
  localparam logic [9:0] IDX_RIGHT_MIX = 10'h039;
  localparam logic [9:0] IDX_LEFT_MIX  = 10'h03A;
  localparam logic [9:0] IDX_LOOPBACK  = 10'h11D;
  localparam logic [9:0] IDX_STATUS    = 10'h11E;

  // ==========================================================================
  // Field positions and codes.
  localparam int NEG_LEFT_BIT  = 5;
  localparam int NEG_RIGHT_BIT = 6;
  localparam int TX_SWAP_BIT   = 8;
  localparam int RX_SWAP_BIT   = 5;
  localparam int GAIN_LSB      = 4;
  localparam int SRC_LSB       = 2;
  localparam int LB_EN_BIT     = 1;
  localparam int LB_SEL_BIT    = 0;
  localparam int SAT_LEFT_BIT  = 0;
  localparam int SAT_RIGHT_BIT = 1;
  localparam logic [1:0] SRC_LEFT   = 2'h1;
  localparam logic [1:0] SRC_RIGHT  = 2'h2;
  localparam logic [1:0] GAIN_UNITY = 2'h3;
  localparam logic [3:0] GAIN_RESET = 4'h0;
  localparam logic [1:0] SRC_RESET  = 2'h0;

  // Gain in Q0.16 for codes 0 (-36 dB) up to 11 (-3 dB), 3 dB apart.
  function automatic logic [15:0] gain_coef(input logic [3:0] code);
    case (code)
      4'h0:    return 16'h040F;
      4'h1:    return 16'h05BB;
      4'h2:    return 16'h0818;
      4'h3:    return 16'h0B6F;
      4'h4:    return 16'h1027;
      4'h5:    return 16'h16D1;
      4'h6:    return 16'h203A;
      4'h7:    return 16'h2D86;
      4'h8:    return 16'h404E;
      4'h9:    return 16'h5AD5;
      4'hA:    return 16'h804D;
      default: return 16'hB53C;
    endcase
  endfunction : gain_coef

endpackage : mix_router_pkg

// >>> hdl/mix_router.sv
// Digital mixing and routing core between converters and the audio port.
//
// Function
// RQ1: Default: left/right inputs to left/right slots.
// RQ2: Default: received slots feed matching output converters.
// RQ3: Input invert bits 6/5 negate right/left.
// RQ4: Transmit swap bit 8 exchanges transmit slots.
// RQ5: Output invert bits 6/5 negate right/left.
// RQ6: Receive swap bit 5 exchanges received slots.
// RQ7: Right sidetone source: 01 left, 10 right.
// RQ8: Left sidetone source at bits 3:2, reset none.
// RQ9: Per-input 4-bit sidetone gain, 3 dB steps.
// RQ10: Scaled sidetone added to received samples.
// RQ11: Sidetone taken from high-pass filtered input.
// RQ12: Software enables inputs first, keeps gains low.
// RQ13: Software keeps pump dynamic power off.
// RQ14: Loopback enable bit 1, reset off.
// RQ15: Select 0: left input, averaged outputs right.
// RQ16: Select 1: averaged outputs left, right input.
// RQ17: Averaged outputs taken after digital volume.
// RQ18: Sums saturate; no loopback means normal routing.
// RQ19: Controls in readable 16-bit registers, reset values.
`timescale 1ns/1ps
module mix_router
  import mix_router_pkg::*;
(
  input  wire logic     core_clk_i,
  input  wire logic     nrst_i,
  input  wire apb_req_t apb_req_i,
  output apb_rsp_t      apb_rsp_o,
  input  wire logic     sample_stb_i,
  input  wire stereo_t  adc_hpf_i,
  input  wire stereo_t  rx_slot_i,
  input  wire stereo_t  dac_vol_i,
  output stereo_t       tx_slot_o,
  output stereo_t       dac_feed_o,
  output logic          sample_vld_o
);

  // ==========================================================================
  // Helper functions.
  // Negation that maps the most negative code to full scale positive.
  function automatic sample_t neg_sat(input sample_t x);
    if (x == SAMPLE_MIN)
      return SAMPLE_MAX;
    return sample_t'(-x);
  endfunction : neg_sat

  // Saturating sum, so a loud sidetone clips instead of wrapping.
  function automatic sample_t sat_add(input sample_t a, input sample_t b);
    logic signed [SAMPLE_W:0] w;
    w = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
    if (w[SAMPLE_W] != w[SAMPLE_W-1])
      return w[SAMPLE_W] ? SAMPLE_MIN : SAMPLE_MAX;
    return w[SAMPLE_W-1:0];
  endfunction : sat_add

  // Half of the sum, rounded down; the extra bit keeps the sum from overflowing.
  function automatic sample_t half_sum(input sample_t a, input sample_t b);
    logic signed [SAMPLE_W:0] w;
    w = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
    return w[SAMPLE_W:1];
  endfunction : half_sum

  // Sidetone scaling; codes with both top bits set pass at unity.
  function automatic sample_t st_scale(input sample_t x,
                                       input logic [3:0] code);
    logic signed [SAMPLE_W+16:0] p;
    p = x * $signed({1'b0, gain_coef(code)});
    if (code[3:2] == GAIN_UNITY)
      return x;
    return p[SAMPLE_W+15:16];
  endfunction : st_scale

  // True for an aligned, mapped register address, else false.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    logic [9:0] i;
    i = a[ADDR_W-1:BYTE_SHIFT];
    if (a[BYTE_SHIFT-1:0] != '0)
      return 1'b0;
    return i == IDX_CTRL_ONE || i == IDX_CTRL_TWO || i == IDX_PORT_ZERO ||
           i == IDX_RIGHT_MIX || i == IDX_LEFT_MIX ||
           i == IDX_LOOPBACK || i == IDX_STATUS;
  endfunction : reg_hit

  // ==========================================================================
  // State of the block.
  typedef struct packed {
    logic       in_neg_l;
    logic       in_neg_r;
    logic       out_neg_l;
    logic       out_neg_r;
    logic       tx_swap;
    logic       rx_swap;
    logic [3:0] gain_r;
    logic [3:0] gain_l;
    logic [1:0] src_r;
    logic [1:0] src_l;
    logic       lb_en;
    logic       lb_sel;
    logic [1:0] sat;
    logic [31:0] rdata;
    stereo_t    tx;
    stereo_t    dac;
    logic       vld;
  } state_t;
  state_t s_q;
  state_t s_d;
  logic       setup;
  logic       access;
  logic [9:0] idx;
  logic [15:0] wmask;
  logic [15:0] wdat;
  sample_t    a_l;
  sample_t    a_r;
  sample_t    r_l;
  sample_t    r_r;
  sample_t    st_l;
  sample_t    st_r;
  sample_t    avg;
  logic [1:0] ovf;
  // ==========================================================================
  // Bus decode; byte lanes select which half of a field word is written.
  assign setup  = apb_req_i.psel && !apb_req_i.penable;
  assign access = apb_req_i.psel && apb_req_i.penable;
  assign idx    = apb_req_i.paddr[ADDR_W-1:BYTE_SHIFT];
  assign wmask  = {{8{apb_req_i.pstrb[1]}}, {8{apb_req_i.pstrb[0]}}};
  assign wdat   = apb_req_i.pwdata[15:0];

  // Zero wait states; an unmapped or unaligned address answers an error.
  always_comb
  begin
    apb_rsp_o.pready  = 1'b1;
    apb_rsp_o.prdata  = s_q.rdata;
    apb_rsp_o.pslverr = access && !reg_hit(apb_req_i.paddr);
  end

  // ==========================================================================
  // Sample datapath, evaluated every cycle and captured on the strobe.
  // Input path: polarity, then the two slots of the transmit side.
  assign a_l = s_q.in_neg_l ? neg_sat(adc_hpf_i.left) : adc_hpf_i.left; // RQ3
  assign a_r = s_q.in_neg_r ? neg_sat(adc_hpf_i.right)
                            : adc_hpf_i.right; // RQ3

  // Receive path: swap inside the port, then per-output polarity.
  always_comb
  begin
    sample_t x_l;
    sample_t x_r;
    x_l = s_q.rx_swap ? rx_slot_i.right : rx_slot_i.left; // RQ6 RQ2
    x_r = s_q.rx_swap ? rx_slot_i.left : rx_slot_i.right; // RQ6 RQ2
    r_l = s_q.out_neg_l ? neg_sat(x_l) : x_l; // RQ5
    r_r = s_q.out_neg_r ? neg_sat(x_r) : x_r; // RQ5
  end

  // Sidetone from the filtered samples; gain belongs to the source input.
  always_comb
  begin
    case (s_q.src_l) // RQ8
      SRC_LEFT:  st_l = st_scale(adc_hpf_i.left, s_q.gain_l); // RQ9 RQ11
      SRC_RIGHT: st_l = st_scale(adc_hpf_i.right, s_q.gain_r); // RQ9 RQ11
      default:   st_l = SAMPLE_ZERO;
    endcase
    case (s_q.src_r) // RQ7
      SRC_LEFT:  st_r = st_scale(adc_hpf_i.left, s_q.gain_l); // RQ9 RQ11
      SRC_RIGHT: st_r = st_scale(adc_hpf_i.right, s_q.gain_r); // RQ9 RQ11
      default:   st_r = SAMPLE_ZERO;
    endcase
  end

  // Overflow of the mix, reported as sticky status bits.
  always_comb
  begin
    logic signed [SAMPLE_W:0] w_l;
    logic signed [SAMPLE_W:0] w_r;
    w_l = {r_l[SAMPLE_W-1], r_l} + {st_l[SAMPLE_W-1], st_l};
    w_r = {r_r[SAMPLE_W-1], r_r} + {st_r[SAMPLE_W-1], st_r};
    ovf[SAT_LEFT_BIT]  = w_l[SAMPLE_W] != w_l[SAMPLE_W-1];
    ovf[SAT_RIGHT_BIT] = w_r[SAMPLE_W] != w_r[SAMPLE_W-1];
  end

  // Post-volume outputs, so a muted channel adds nothing to the average.
  assign avg = half_sum(dac_vol_i.left, dac_vol_i.right); // RQ17

  // ==========================================================================
  // Next state: register writes, read capture and sample capture.
  always_comb
  begin
    logic [1:0] clr;
    s_d = s_q;
    clr = '0;
    // Read data is latched in the setup cycle so it leaves a flip-flop.
    if (setup)
    begin
      s_d.rdata = '0;
      case (reg_hit(apb_req_i.paddr) ? idx : '0) // RQ19
        IDX_CTRL_ONE:
        begin
          s_d.rdata[NEG_LEFT_BIT]  = s_q.in_neg_l;
          s_d.rdata[NEG_RIGHT_BIT] = s_q.in_neg_r;
        end
        IDX_CTRL_TWO:
        begin
          s_d.rdata[NEG_LEFT_BIT]  = s_q.out_neg_l;
          s_d.rdata[NEG_RIGHT_BIT] = s_q.out_neg_r;
        end
        IDX_PORT_ZERO:
        begin
          s_d.rdata[TX_SWAP_BIT] = s_q.tx_swap;
          s_d.rdata[RX_SWAP_BIT] = s_q.rx_swap;
        end
        IDX_RIGHT_MIX:
        begin
          s_d.rdata[GAIN_LSB+:4] = s_q.gain_r;
          s_d.rdata[SRC_LSB+:2]  = s_q.src_r;
        end
        IDX_LEFT_MIX:
        begin
          s_d.rdata[GAIN_LSB+:4] = s_q.gain_l;
          s_d.rdata[SRC_LSB+:2]  = s_q.src_l;
        end
        IDX_LOOPBACK:
        begin
          s_d.rdata[LB_EN_BIT]  = s_q.lb_en;
          s_d.rdata[LB_SEL_BIT] = s_q.lb_sel;
        end
        IDX_STATUS:
          s_d.rdata[SAT_RIGHT_BIT:SAT_LEFT_BIT] = s_q.sat;
        default:
          s_d.rdata = '0;
      endcase
    end
    // Writes take effect in the access cycle; strobes gate the lanes.
    if (access && apb_req_i.pwrite && reg_hit(apb_req_i.paddr))
    begin
      case (idx) // RQ19
        IDX_CTRL_ONE:
        begin
          if (wmask[NEG_LEFT_BIT])
            s_d.in_neg_l = wdat[NEG_LEFT_BIT];
          if (wmask[NEG_RIGHT_BIT])
            s_d.in_neg_r = wdat[NEG_RIGHT_BIT];
        end
        IDX_CTRL_TWO:
        begin
          if (wmask[NEG_LEFT_BIT])
            s_d.out_neg_l = wdat[NEG_LEFT_BIT];
          if (wmask[NEG_RIGHT_BIT])
            s_d.out_neg_r = wdat[NEG_RIGHT_BIT];
        end
        IDX_PORT_ZERO:
        begin
          if (wmask[TX_SWAP_BIT])
            s_d.tx_swap = wdat[TX_SWAP_BIT];
          if (wmask[RX_SWAP_BIT])
            s_d.rx_swap = wdat[RX_SWAP_BIT];
        end
        IDX_RIGHT_MIX:
          if (wmask[GAIN_LSB])
          begin
            s_d.gain_r = wdat[GAIN_LSB+:4];
            s_d.src_r  = wdat[SRC_LSB+:2];
          end
        IDX_LEFT_MIX:
          if (wmask[GAIN_LSB])
          begin
            s_d.gain_l = wdat[GAIN_LSB+:4];
            s_d.src_l  = wdat[SRC_LSB+:2];
          end
        IDX_LOOPBACK:
          if (wmask[LB_EN_BIT])
          begin
            s_d.lb_en  = wdat[LB_EN_BIT]; // RQ14
            s_d.lb_sel = wdat[LB_SEL_BIT];
          end
        IDX_STATUS:
          clr = wdat[SAT_RIGHT_BIT:SAT_LEFT_BIT] &
                wmask[SAT_RIGHT_BIT:SAT_LEFT_BIT];
        default:
          clr = '0;
      endcase
    end
    // Capture one frame per strobe; the valid flag marks new outputs.
    s_d.vld = sample_stb_i;
    if (sample_stb_i)
    begin
      s_d.dac.left  = sat_add(r_l, st_l); // RQ10 RQ18
      s_d.dac.right = sat_add(r_r, st_r); // RQ10 RQ18
      if (!s_q.lb_en)
      begin
        s_d.tx.left  = s_q.tx_swap ? a_r : a_l; // RQ1 RQ4 RQ18
        s_d.tx.right = s_q.tx_swap ? a_l : a_r; // RQ1 RQ4 RQ18
      end
      else if (!s_q.lb_sel)
      begin
        s_d.tx.left  = a_l; // RQ15
        s_d.tx.right = avg; // RQ15
      end
      else
      begin
        s_d.tx.left  = avg; // RQ16
        s_d.tx.right = a_r; // RQ16
      end
    end
    // A new overflow wins over a clear in the same cycle.
    s_d.sat = (s_q.sat & ~clr) | (sample_stb_i ? ovf : 2'h0); // RQ18
  end

  // ==========================================================================
  // State register; every field resets to zero.
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_q <= '0; // RQ19 RQ14
    else
      s_q <= s_d;
  end

  assign tx_slot_o    = s_q.tx;
  assign dac_feed_o   = s_q.dac;
  assign sample_vld_o = s_q.vld;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic plain_rx;
  logic plain_tx;
  assign plain_tx = !s_q.lb_en && !s_q.in_neg_l && !s_q.in_neg_r;
  assign plain_rx = s_q.src_l == SRC_RESET && s_q.src_r == SRC_RESET &&
                    !s_q.out_neg_l && !s_q.out_neg_r;
  tx_default_a: assert property ( // RQ1
    sample_stb_i && plain_tx && !s_q.tx_swap |=>
      tx_slot_o == $past(adc_hpf_i) && sample_vld_o)
    else $error("transmit slots not in default order");
  rx_default_a: assert property ( // RQ2
    sample_stb_i && plain_rx && !s_q.rx_swap |=>
      dac_feed_o == $past(rx_slot_i))
    else $error("receive slots not in default order");
  in_negate_a: assert property ( // RQ3
    sample_stb_i && !s_q.lb_en && !s_q.tx_swap && s_q.in_neg_r &&
    adc_hpf_i.right != SAMPLE_MIN |=>
      tx_slot_o.right == -$past(adc_hpf_i.right))
    else $error("right input not negated");
  tx_swap_a: assert property ( // RQ4
    sample_stb_i && plain_tx && s_q.tx_swap |=>
      tx_slot_o.left == $past(adc_hpf_i.right) &&
      tx_slot_o.right == $past(adc_hpf_i.left))
    else $error("transmit slots not swapped");
  out_negate_a: assert property ( // RQ5
    sample_stb_i && s_q.src_l == SRC_RESET && !s_q.rx_swap &&
    s_q.out_neg_l && rx_slot_i.left != SAMPLE_MIN |=>
      dac_feed_o.left == -$past(rx_slot_i.left))
    else $error("left output not negated");
  rx_swap_a: assert property ( // RQ6
    sample_stb_i && plain_rx && s_q.rx_swap |=>
      dac_feed_o.left == $past(rx_slot_i.right) &&
      dac_feed_o.right == $past(rx_slot_i.left))
    else $error("received slots not swapped");
  side_unity_a: assert property ( // RQ10
    sample_stb_i && !s_q.out_neg_l && !s_q.rx_swap &&
    s_q.src_l == SRC_LEFT && s_q.gain_l[3:2] == GAIN_UNITY |=>
      dac_feed_o.left ==
        sat_add($past(rx_slot_i.left), $past(adc_hpf_i.left)))
    else $error("left sidetone not mixed at unity");
  side_off_a: assert property ( // RQ7
    sample_stb_i && !s_q.out_neg_r && !s_q.rx_swap &&
    s_q.src_r == GAIN_UNITY |=> dac_feed_o.right == $past(rx_slot_i.right))
    else $error("disabled sidetone still mixed");
  lb_sel0_a: assert property ( // RQ15
    sample_stb_i && s_q.lb_en && !s_q.lb_sel && !s_q.in_neg_l |=>
      tx_slot_o.left == $past(adc_hpf_i.left) &&
      tx_slot_o.right == half_sum($past(dac_vol_i.left),
                                  $past(dac_vol_i.right)))
    else $error("loopback select 0 slots wrong");
  lb_sel1_a: assert property ( // RQ16
    sample_stb_i && s_q.lb_en && s_q.lb_sel && !s_q.in_neg_r |=>
      tx_slot_o.right == $past(adc_hpf_i.right) &&
      tx_slot_o.left == half_sum($past(dac_vol_i.left),
                                 $past(dac_vol_i.right)))
    else $error("loopback select 1 slots wrong");
  mix_clip_a: assert property ( // RQ18
    sample_stb_i && ovf[SAT_LEFT_BIT] |=>
      (dac_feed_o.left == SAMPLE_MAX || dac_feed_o.left == SAMPLE_MIN) &&
      s_q.sat[SAT_LEFT_BIT])
    else $error("left mix wrapped instead of clipping");
  hold_out_a: assert property ( // RQ18
    !sample_stb_i |=> $stable(tx_slot_o) && $stable(dac_feed_o) &&
      !sample_vld_o)
    else $error("outputs changed without a strobe");
  cv_loopback_c: cover property (sample_stb_i && s_q.lb_en);
  cv_sidetone_c: cover property (sample_stb_i && s_q.src_l == SRC_RIGHT);
  cv_clip_c:     cover property (sample_stb_i && ovf != 2'h0);
  cv_swap_c:     cover property (sample_stb_i && s_q.tx_swap &&
                                 s_q.rx_swap);

endmodule : mix_router

// >>> verification/audio_port_peer.sv
// Behavioural model of the external processor on the audio port.
`timescale 1ns/1ps
module audio_port_peer
  import mix_router_pkg::*;
(
  input  wire logic    core_clk_i,
  input  wire logic    nrst_i,
  input  wire logic    stb_i,
  input  wire stereo_t next_rx_i,
  input  wire stereo_t tx_slot_i,
  input  wire logic    vld_i,
  output stereo_t      rx_slot_o,
  output stereo_t      heard_o
);
  // ==========================================================================
  // Receive slots.
  // Slot data means something only in the strobe cycle; elsewhere the line
  // shows the inverse so that a capture at the wrong moment cannot pass.
  assign rx_slot_o = stb_i ? next_rx_i : ~next_rx_i;

  // ==========================================================================
  // Transmit capture.
  // Each frame the router marks valid is taken, as the processor would.
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      heard_o <= '0;
    else if (vld_i)
      heard_o <= tx_slot_i;
  end
endmodule : audio_port_peer

// >>> verification/tb.sv
// Self-checking testbench of the mixing router and its audio port peer.
`timescale 1ns/1ps
module tb;
  import mix_router_pkg::*;
  // ==========================================================================
  // Signals.
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  apb_req_t    req = '0;
  apb_rsp_t    rsp;
  logic        stb = 1'b0;
  stereo_t     adc = '0;
  stereo_t     vol = '0;
  stereo_t     next_rx = '0;
  stereo_t     rx_line;
  stereo_t     tx;
  stereo_t     feed;
  stereo_t     heard;
  logic        vld;
  int          err_total = 0;
  int          compares = 0;
  logic [31:0] rd;
  logic        err;
  real         want;
  real         tol;
  localparam logic [9:0]  IDX [6] = '{IDX_CTRL_ONE, IDX_CTRL_TWO,
    IDX_PORT_ZERO, IDX_RIGHT_MIX, IDX_LEFT_MIX, IDX_LOOPBACK};
  localparam logic [15:0] MSK [6] = '{16'h0060, 16'h0060, 16'h0120,
    16'h00FC, 16'h00FC, 16'h0003};

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  // ==========================================================================
  // Instances.
  mix_router dut_u (
    .core_clk_i   (clk),
    .nrst_i       (nrst),
    .apb_req_i    (req),
    .apb_rsp_o    (rsp),
    .sample_stb_i (stb),
    .adc_hpf_i    (adc),
    .rx_slot_i    (rx_line),
    .dac_vol_i    (vol),
    .tx_slot_o    (tx),
    .dac_feed_o   (feed),
    .sample_vld_o (vld)
  );
  audio_port_peer peer_u (
    .core_clk_i (clk),
    .nrst_i     (nrst),
    .stb_i      (stb),
    .next_rx_i  (next_rx),
    .tx_slot_i  (tx),
    .vld_i      (vld),
    .rx_slot_o  (rx_line),
    .heard_o    (heard)
  );

  // ==========================================================================
  // Helpers.
  function automatic sample_t neg(input sample_t s);
    return (s == SAMPLE_MIN) ? SAMPLE_MAX : -s;
  endfunction : neg

  function automatic logic [11:0] adr(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction : adr

  function automatic sample_t pick(input logic [1:0] c, input stereo_t a);
    return (c == 2'h1) ? a.left : (c == 2'h2) ? a.right : SAMPLE_ZERO;
  endfunction : pick

  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] st);
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    req.pstrb   <= st;
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for a slave that never answers.
    while (rsp.pready !== 1'b1)
      @(posedge clk);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    check("register read", rd, exp);
  endtask : rdchk

  // One sample frame; inputs show their inverse outside the strobe cycle.
  task automatic frame(input stereo_t a, input stereo_t r, input stereo_t v);
    @(posedge clk);
    adc     <= a;
    next_rx <= r;
    vol     <= v;
    stb     <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    adc <= ~a;
    vol <= ~v;
    #1;
    check("valid pulse", vld, 1'b1);
  endtask : frame

  // ==========================================================================
  // Watchdog: far beyond the few hundred cycles the tests take.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, writable bits and refused accesses.
    for (int i = 0; i < 6; i++)
    begin
      rdchk(adr(IDX[i]), 32'h0);
      wr(adr(IDX[i]), 32'hFFFFFFFF);
      rdchk(adr(IDX[i]), {16'h0, MSK[i]});
      wr(adr(IDX[i]), 32'h0);
    end
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, 12'h015, 32'hFFFF, 4'hF);
    check("unaligned error", err, 1'b1);
    rdchk(adr(IDX_CTRL_ONE), 32'h0);
    apb(1'b1, adr(IDX_PORT_ZERO), 32'hFFFF, 4'h1);
    rdchk(adr(IDX_PORT_ZERO), 32'h20);
    wr(adr(IDX_PORT_ZERO), 32'h0);
    // Default routing in both directions.
    frame({24'h123456, 24'h7ABCDE}, {24'h0F0F0F, 24'h808080}, '0);
    check("tx default", tx, {24'h123456, 24'h7ABCDE});
    check("feed default", feed, {24'h0F0F0F, 24'h808080});
    @(posedge clk);
    #1;
    check("peer heard", heard, {24'h123456, 24'h7ABCDE});
    // Input negation, the most negative sample included, then swap.
    wr(adr(IDX_CTRL_ONE), 32'h60);
    apb(1'b0, 12'h015, 32'h0, 4'h0);
    check("unaligned data", rd, 32'h0);
    frame({SAMPLE_MIN, 24'h000005}, '0, '0);
    check("tx negate", tx, {SAMPLE_MAX, neg(24'sh5)});
    wr(adr(IDX_CTRL_ONE), 32'h40);
    frame({24'h000005, 24'h000007}, '0, '0);
    check("tx negate right", tx, {24'sh5, neg(24'sh7)});
    wr(adr(IDX_CTRL_ONE), 32'h0);
    wr(adr(IDX_PORT_ZERO), 32'h100);
    frame({24'h000001, 24'h000002}, '0, '0);
    check("tx swap", tx, {24'h000002, 24'h000001});
    // Receive swap runs ahead of the output negation.
    wr(adr(IDX_PORT_ZERO), 32'h20);
    wr(adr(IDX_CTRL_TWO), 32'h20);
    frame('0, {24'h000011, 24'h000022}, '0);
    check("rx swap negate", feed, {neg(24'sh22), 24'sh11});
    wr(adr(IDX_PORT_ZERO), 32'h0);
    wr(adr(IDX_CTRL_TWO), 32'h40);
    frame('0, {24'h000011, 24'h000022}, '0);
    check("rx negate right", feed, {24'sh11, neg(24'sh22)});
    wr(adr(IDX_CTRL_TWO), 32'h0);
    // Every source code on both outputs, unity gain kept low.
    for (int s = 0; s < 4; s++)
    begin
      wr(adr(IDX_RIGHT_MIX), {24'h0, 4'hC, s[1:0], 2'b00});
      wr(adr(IDX_LEFT_MIX), {24'h0, 4'hC, 2'(3 - s), 2'b00});
      frame({24'h001000, 24'h000020}, {24'h000100, 24'h000200}, '0);
      check("sidetone", feed, {24'sh100 + pick(2'(3 - s), adc ^ '1),
        24'sh200 + pick(s[1:0], adc ^ '1)});
    end
    // Mixed sums clip at full scale; the sticky flags record it.
    wr(adr(IDX_RIGHT_MIX), 32'hC8);
    wr(adr(IDX_LEFT_MIX), 32'hC4);
    frame({24'h000100, -24'sh100}, {24'h7FFFF0, 24'h800010}, '0);
    check("saturate", feed, {SAMPLE_MAX, SAMPLE_MIN});
    rdchk(adr(IDX_STATUS), 32'h3);
    wr(adr(IDX_STATUS), 32'h3);
    rdchk(adr(IDX_STATUS), 32'h0);
    // Each gain code in 3 dB steps, codes from 12 up at unity.
    wr(adr(IDX_LEFT_MIX), 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      wr(adr(IDX_RIGHT_MIX), {24'h0, 4'(c), 4'h8});
      frame({24'h0, 24'h100000}, '0, '0);
      want = 1048576.0 * (10.0 ** ((3.0 * ((c > 11) ? 12 : c) - 36.0)
        / 20.0));
      tol  = want * 0.001 + 1.0;
      check("gain", ($itor(feed.right) > want - tol) &&
        ($itor(feed.right) < want + tol), 1'b1);
    end
    wr(adr(IDX_RIGHT_MIX), 32'h0);
    // Loopback off leaves normal routing even with the select bit set.
    wr(adr(IDX_LOOPBACK), 32'h1);
    frame({24'h000111, 24'h000222}, '0, {24'h000100, 24'h000301});
    check("loop off", tx, {24'h000111, 24'h000222});
    wr(adr(IDX_LOOPBACK), 32'h2);
    frame({24'h000111, 24'h000222}, '0, {24'h000100, 24'h000301});
    check("loop sel 0", tx, {24'h000111, 24'h000200});
    wr(adr(IDX_LOOPBACK), 32'h3);
    frame({24'h000111, 24'h000222}, '0, {SAMPLE_MIN, SAMPLE_MIN});
    check("loop sel 1", tx, {SAMPLE_MIN, 24'h000222});
    frame({24'h000111, 24'h000222}, '0, {24'h000400, 24'h0});
    check("loop zero vol", tx, {24'h000200, 24'h000222});
    end_of_test();
  end
endmodule : tb
